// File: logic/spi_port_consts.vh
// Constants for the four-pin serial port: register map, fields, resets, timing
//
// Summary of operation
// - Word length one to sixteen, full duplex
// - Master drives serial clock, slave accepts it
// - 125 bit-rate settings, clock divided down
// - Falling scheme no delay: change fall, sample rise
// - Falling scheme delayed: bit half-cycle early
// - Rising scheme no delay: idle low
// - Rising scheme delayed: bit half-cycle early
// - Polarity and phase bits pick scheme
// - Transmit can be disabled, receive continues
// - Interrupt request or polled status flags
// - Nine registers at frame base 7040h
// - Data in bits 7-0, upper reads zero
// - Four pins: data out, data in, enable, clock
// - Pin-function bit clear: all four pins become general-purpose I/O
`ifndef SPI_PORT_CONSTS_VH
`define SPI_PORT_CONSTS_VH

`define FRAME_BASE        16'h7040
`define REG_CFG           4'h0
`define REG_CTRL          4'h1
`define REG_STATUS        4'h2
`define REG_RATE          4'h3
`define REG_RX_HI         4'h4
`define REG_RX_LO         4'h5
`define REG_TX_HI         4'h6
`define REG_TX_LO         4'h7
`define REG_PINS          4'h8

`define CFG_RUN_BIT       7
`define CFG_POL_BIT       6
`define CFG_PINFN_BIT     5
`define CTRL_MASTER_BIT   0
`define CTRL_TXEN_BIT     1
`define CTRL_IRQEN_BIT    2
`define CTRL_PHASE_BIT    3
`define STAT_DONE_BIT     7
`define STAT_OVR_BIT      6
`define STAT_BUSY_BIT     5

`define CFG_RESET         8'h0f
`define CTRL_RESET        8'h02
`define RATE_RESET        7'h7f
`define RATE_MIN          7'h03

`define PIN_SOMI          0
`define PIN_SIMO          1
`define PIN_STE           2
`define PIN_SCLK          3

`endif

// File: logic/pin_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 4
) (
  input  wire             sys_clk_in,
  input  wire             srst_in,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;
  integer i;

  // Only the second stage reads the first; the filter looks at stages two and three
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
      stage3_reg <= {WIDTH{1'b0}};
      level_out  <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          level_out[i] <= stage3_reg[i];
        end
      end
    end
  end
endmodule // pin_sync
`default_nettype wire

// File: logic/serial_port.v
// Four-pin synchronous serial port with register port, master and slave modes
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_consts.vh"
module serial_port (
  input  wire        sys_clk_in,
  input  wire        srst_in,
  input  wire [3:0]  addr_in,
  input  wire [15:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [15:0] rdata_out,
  output reg         irq_out,
  input  wire        slave_out_master_in_pin_in,
  output reg         slave_out_master_in_pin_out,
  output reg         slave_out_master_in_pin_oe_out,
  input  wire        slave_in_master_out_pin_in,
  output reg         slave_in_master_out_pin_out,
  output reg         slave_in_master_out_pin_oe_out,
  input  wire        slave_transmit_enable_pin_in,
  output reg         slave_transmit_enable_pin_out,
  output reg         slave_transmit_enable_pin_oe_out,
  input  wire        serial_clock_pin_in,
  output reg         serial_clock_pin_out,
  output reg         serial_clock_pin_oe_out
);
  // Register file
  reg  [7:0]  cfg_reg;
  reg  [7:0]  ctrl_reg;
  reg  [6:0]  rate_reg;
  reg  [15:0] tx_buf_reg;
  reg  [15:0] rx_buf_reg;
  reg  [7:0]  pins_reg;
  reg         done_reg;
  reg         ovr_reg;

  // Shift engine
  reg         busy_reg;
  reg  [4:0]  phase_reg;
  reg  [6:0]  div_cnt_reg;
  reg         sclk_reg;
  reg  [15:0] tx_sh_reg;
  reg  [15:0] rx_sh_reg;
  reg  [3:0]  bit_cnt_reg;
  reg         sclk_prev_reg;
  reg         tx_pending_reg;

  wire [3:0]  pin_level;
  wire        run        = cfg_reg[`CFG_RUN_BIT];
  wire        pol        = cfg_reg[`CFG_POL_BIT];
  wire        pin_fn     = cfg_reg[`CFG_PINFN_BIT];
  wire [3:0]  word_last  = cfg_reg[3:0];
  wire        master     = ctrl_reg[`CTRL_MASTER_BIT];
  wire        tx_en      = ctrl_reg[`CTRL_TXEN_BIT];
  wire        irq_en     = ctrl_reg[`CTRL_IRQEN_BIT];
  wire        cpha       = ctrl_reg[`CTRL_PHASE_BIT];

  // Mask of the low bits that belong to a word of word_last+1 bits
  function [15:0] word_mask;
    input [3:0] last;
    begin
      word_mask = 16'hffff >> (4'hf - last);
    end
  endfunction

  // Register index match, shared by the read and write decoders
  function hit;
    input [3:0] addr;
    input [3:0] idx;
    begin
      hit = (addr == idx);
    end
  endfunction

  pin_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .async_in   ({serial_clock_pin_in, slave_transmit_enable_pin_in,
                  slave_in_master_out_pin_in, slave_out_master_in_pin_in}),
    .level_out  (pin_level)
  );

  // Rates below the minimum clamp to it, leaving 125 usable settings
  wire [6:0]  rate_eff   = (rate_reg < `RATE_MIN) ? `RATE_MIN : rate_reg;
  wire        tick       = (div_cnt_reg == rate_eff);
  wire [4:0]  phase_end  = {word_last, 1'b1};
  wire [4:0]  phase_nx   = phase_reg + 5'h01;

  wire        wr_tx_lo   = wr_in && hit(addr_in, `REG_TX_LO);
  wire        rd_rx_lo   = rd_in && hit(addr_in, `REG_RX_LO);
  wire [15:0] tx_word    = wr_tx_lo ? {tx_buf_reg[15:8], wdata_in[7:0]} : tx_buf_reg;

  // Slave side edge detection on the synchronised clock pin
  wire        s_clk      = pin_level[`PIN_SCLK];
  wire        s_sel      = pin_fn && run && !master && !pin_level[`PIN_STE];
  wire        s_edge     = s_sel && (s_clk != sclk_prev_reg);
  wire        s_lead     = s_edge && (s_clk != pol);
  wire        s_trail    = s_edge && (s_clk == pol);
  wire        s_sample   = cpha ? s_lead : s_trail;
  wire        s_shift    = (cpha ? s_trail : s_lead) && (bit_cnt_reg != 4'h0);

  // Master start: write to the low transmit byte, or a write held while busy
  wire        m_start    = run && master && pin_fn && !busy_reg && (wr_tx_lo || tx_pending_reg);

  wire        m_done     = busy_reg && tick && (phase_reg == phase_end);
  wire        m_sample   = busy_reg && tick && !m_done && phase_nx[0];
  wire        m_shift    = busy_reg && tick && !m_done && !phase_nx[0];
  wire        s_done     = s_sample && (bit_cnt_reg == word_last);
  wire        rx_bit     = master ? pin_level[`PIN_SOMI] : pin_level[`PIN_SIMO];
  wire [15:0] rx_next    = {rx_sh_reg[14:0], rx_bit};
  wire        word_done  = m_done || s_done;

  // Register writes and status flags
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      cfg_reg    <= `CFG_RESET;
      ctrl_reg   <= `CTRL_RESET;
      rate_reg   <= `RATE_RESET;
      tx_buf_reg <= 16'h0000;
      pins_reg   <= 8'h00;
      done_reg   <= 1'b0;
      ovr_reg    <= 1'b0;
    end else begin
      // Upper data byte is ignored on every write
      if (wr_in) begin
        if (hit(addr_in, `REG_CFG)) begin
          cfg_reg <= wdata_in[7:0];
        end else if (hit(addr_in, `REG_CTRL)) begin
          ctrl_reg <= wdata_in[7:0];
        end else if (hit(addr_in, `REG_RATE)) begin
          rate_reg <= wdata_in[6:0];
        end else if (hit(addr_in, `REG_TX_HI)) begin
          tx_buf_reg[15:8] <= wdata_in[7:0];
        end else if (hit(addr_in, `REG_TX_LO)) begin
          tx_buf_reg[7:0] <= wdata_in[7:0];
        end else if (hit(addr_in, `REG_PINS)) begin
          pins_reg <= wdata_in[7:0];
        end
      end
      // Completion sets the flag even when it is read away in the same cycle
      if (word_done) begin
        done_reg <= 1'b1;
      end else if (rd_rx_lo) begin
        done_reg <= 1'b0;
      end
      if (word_done && done_reg && !rd_rx_lo) begin
        ovr_reg <= 1'b1;
      end else if (wr_in && hit(addr_in, `REG_STATUS) && wdata_in[`STAT_OVR_BIT]) begin
        ovr_reg <= 1'b0;
      end
    end
  end

  // Shift engine for both roles
  always @(posedge sys_clk_in) begin
    if (srst_in || !run) begin
      // Software reset parks the clock at its idle level, clears the bit counters and drops the word in progress
      busy_reg       <= 1'b0;
      phase_reg      <= 5'h00;
      div_cnt_reg    <= 7'h00;
      sclk_reg       <= srst_in ? 1'b0 : pol;
      bit_cnt_reg    <= 4'h0;
      tx_sh_reg      <= srst_in ? 16'h0000 : tx_buf_reg;
      rx_sh_reg      <= 16'h0000;
      sclk_prev_reg  <= srst_in ? 1'b0 : pol;
      tx_pending_reg <= 1'b0;
      rx_buf_reg     <= srst_in ? 16'h0000 : rx_buf_reg;
    end else begin
      sclk_prev_reg <= s_clk;
      if (wr_tx_lo && master && busy_reg) begin
        tx_pending_reg <= 1'b1;
      end else if (m_start) begin
        tx_pending_reg <= 1'b0;
      end
      div_cnt_reg <= (tick || !busy_reg) ? 7'h00 : div_cnt_reg + 7'h01;
      if (master) begin
        // First bit goes out at start; with no phase delay the clock goes active at once
        if (m_start) begin
          busy_reg  <= 1'b1;
          phase_reg <= 5'h00;
          tx_sh_reg <= tx_word;
          sclk_reg  <= pol ^ ~cpha;
        end else if (m_done) begin
          busy_reg   <= 1'b0;
          sclk_reg   <= pol;
          rx_buf_reg <= rx_sh_reg & word_mask(word_last);
        end else if (busy_reg && tick) begin
          phase_reg <= phase_nx;
          // Clock active on even half-periods without delay, odd ones with delay
          sclk_reg  <= pol ^ (cpha ? phase_nx[0] : ~phase_nx[0]);
        end else if (!busy_reg) begin
          sclk_reg <= pol;
        end
        if (m_sample) begin
          rx_sh_reg <= rx_next;
        end
        if (m_shift) begin
          tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
        end
      end else begin
        busy_reg <= 1'b0;
        sclk_reg <= pol;
        if (!s_sel) begin
          // Deselected slave restarts its word and reloads the next outgoing one
          bit_cnt_reg <= 4'h0;
          tx_sh_reg   <= tx_word;
        end else if (s_done) begin
          bit_cnt_reg <= 4'h0;
          rx_buf_reg  <= rx_next & word_mask(word_last);
          tx_sh_reg   <= tx_word;
        end else begin
          if (s_sample) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            rx_sh_reg   <= rx_next;
          end
          if (s_shift) begin
            tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
          end else if (wr_tx_lo && bit_cnt_reg == 4'h0 && !s_sample) begin
            tx_sh_reg <= tx_word;
          end
        end
      end
    end
  end

  // Pin drive: port function or general-purpose I/O
  reg [3:0] pin_out_next;
  reg [3:0] pin_oe_next;
  wire      data_bit = tx_sh_reg[word_last];

  always @* begin
    pin_out_next = pins_reg[7:4];
    pin_oe_next  = pins_reg[3:0];
    if (pin_fn) begin
      pin_out_next = 4'h0;
      pin_oe_next  = 4'h0;
      if (master) begin
        pin_out_next[`PIN_SCLK] = sclk_reg;
        pin_oe_next[`PIN_SCLK]  = 1'b1;
        pin_out_next[`PIN_SIMO] = data_bit;
        pin_oe_next[`PIN_SIMO]  = tx_en;
      end else begin
        // Slave drives its data line only while selected
        pin_out_next[`PIN_SOMI] = data_bit;
        pin_oe_next[`PIN_SOMI]  = tx_en && s_sel;
      end
    end
  end

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      slave_out_master_in_pin_out      <= 1'b0;
      slave_out_master_in_pin_oe_out   <= 1'b0;
      slave_in_master_out_pin_out      <= 1'b0;
      slave_in_master_out_pin_oe_out   <= 1'b0;
      slave_transmit_enable_pin_out    <= 1'b0;
      slave_transmit_enable_pin_oe_out <= 1'b0;
      serial_clock_pin_out             <= 1'b0;
      serial_clock_pin_oe_out          <= 1'b0;
      irq_out                          <= 1'b0;
    end else begin
      slave_out_master_in_pin_out      <= pin_out_next[`PIN_SOMI];
      slave_out_master_in_pin_oe_out   <= pin_oe_next[`PIN_SOMI];
      slave_in_master_out_pin_out      <= pin_out_next[`PIN_SIMO];
      slave_in_master_out_pin_oe_out   <= pin_oe_next[`PIN_SIMO];
      slave_transmit_enable_pin_out    <= pin_out_next[`PIN_STE];
      slave_transmit_enable_pin_oe_out <= pin_oe_next[`PIN_STE];
      serial_clock_pin_out             <= pin_out_next[`PIN_SCLK];
      serial_clock_pin_oe_out          <= pin_oe_next[`PIN_SCLK];
      irq_out                          <= done_reg && irq_en;
    end
  end

  // Register reads: one cycle later, upper byte always zero
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (hit(addr_in, `REG_CFG)) begin
      rd_byte = cfg_reg;
    end else if (hit(addr_in, `REG_CTRL)) begin
      rd_byte = ctrl_reg;
    end else if (hit(addr_in, `REG_STATUS)) begin
      rd_byte = {done_reg, ovr_reg, busy_reg, 5'h00};
    end else if (hit(addr_in, `REG_RATE)) begin
      rd_byte = {1'b0, rate_reg};
    end else if (hit(addr_in, `REG_RX_HI)) begin
      rd_byte = rx_buf_reg[15:8];
    end else if (hit(addr_in, `REG_RX_LO)) begin
      rd_byte = rx_buf_reg[7:0];
    end else if (hit(addr_in, `REG_TX_HI)) begin
      rd_byte = tx_buf_reg[15:8];
    end else if (hit(addr_in, `REG_TX_LO)) begin
      rd_byte = tx_buf_reg[7:0];
    end else if (hit(addr_in, `REG_PINS)) begin
      // Pin levels let software check the clock idle level before selecting
      rd_byte = {pin_level, pins_reg[3:0]};
    end
  end

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= rd_in ? {8'h00, rd_byte} : 16'h0000;
    end
  end
endmodule // serial_port
`default_nettype wire

// File: test/serial_port_properties.sv
// Port-level assertions for the four-pin serial port
`timescale 1ns/10ps
`default_nettype none
module serial_port_properties (
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic [3:0]  addr_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic        irq_out,
  input wire logic        slave_in_master_out_pin_out,
  input wire logic        slave_in_master_out_pin_oe_out,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe_out
);
  logic [2:0] wr_hist;
  // Register writes may legally move pins for a few cycles
  wire logic  quiet = !wr_in && (wr_hist == 3'h0);
  always @(posedge sys_clk_in) begin
    wr_hist <= srst_in ? 3'h0 : {wr_hist[1:0], wr_in};
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  upper_byte_zero_a: assert property (
    rdata_out[15:8] == 8'h00) else $error("upper read byte set");
  read_idle_zero_a: assert property (
    !$past(rd_in) |-> rdata_out == 16'h0000) else $error("data outside read slot");
  unmapped_zero_a: assert property (
    $past(rd_in) && $past(addr_in) > 4'h8 |-> rdata_out == 16'h0000)
    else $error("unmapped index returned data");
  reset_idle_a: assert property (
    $fell(srst_in) |-> !irq_out && !serial_clock_pin_out && !serial_clock_pin_oe_out
      && !slave_in_master_out_pin_oe_out) else $error("outputs active after reset");
  data_after_edge_a: assert property (
    $changed(serial_clock_pin_out) |=> ($stable(slave_in_master_out_pin_out) || !quiet)[*3])
    else $error("data moved inside half period");
  clock_half_min_a: assert property (
    $changed(serial_clock_pin_out) |=> ($stable(serial_clock_pin_out) || !quiet)[*3])
    else $error("serial clock half period too short");
  irq_clear_cause_a: assert property (
    $fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2)
      || ($past(rd_in, 2) && $past(addr_in, 2) == 4'h5)) else $error("request dropped alone");
  pin_dir_write_a: assert property (
    $changed(serial_clock_pin_oe_out) |-> !quiet) else $error("clock drive changed alone");
endmodule // serial_port_properties

bind serial_port serial_port_properties chk_i (.sys_clk_in, .srst_in, .addr_in, .wr_in,
  .rd_in, .rdata_out, .irq_out, .slave_in_master_out_pin_out,
  .slave_in_master_out_pin_oe_out, .serial_clock_pin_out, .serial_clock_pin_oe_out);
`default_nettype wire

// File: test/link_partner.sv
// Behavioural slave peripheral on the far side of the serial link
`timescale 1ns/10ps
`default_nettype none
module link_partner (
  input  wire logic        sclk_in,
  input  wire logic        sel_n_in,
  input  wire logic        pol_in,
  input  wire logic        pha_in,
  input  wire logic        slow_in,
  input  wire logic [4:0]  len_in,
  input  wire logic [15:0] word_in,
  input  wire logic        simo_in,
  output var  logic        somi_out,
  output var  logic [15:0] rx_out
);
  logic [15:0] sh;
  logic [4:0]  cnt;
  initial somi_out = 1'h0;
  always @(negedge sel_n_in) begin
    sh = word_in;
    cnt = 5'h00;
    rx_out = 16'h0000;
  end
  // Sample on one edge, shift only after the first sample
  always @(sclk_in) begin
    if (!sel_n_in && ((sclk_in != pol_in) == pha_in)) begin
      rx_out = {rx_out[14:0], simo_in};
      cnt = cnt + 5'h01;
    end else if (!sel_n_in && cnt != 5'h00) begin
      sh = sh << 1;
    end
  end
  // Released line shows the inverse of its last level, not a held copy
  always @(sh, sel_n_in, len_in) begin
    somi_out <= #(slow_in ? 12 : 0) (sel_n_in ? ~somi_out : sh[len_in - 5'h01]);
  end
endmodule // link_partner
`default_nettype wire

// File: test/tb.sv
// Self-checking bench: serial port as master against a slave model
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        sys_clk_in;
  logic        srst_in = 1'h1;
  logic        wr_in = 1'h0;
  logic        rd_in = 1'h0;
  logic [3:0]  addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic [15:0] rdata, rd_q, tx, pw, prx;
  logic        irq, somi_o, somi_oe, simo_o, simo_oe, ste_o, ste_oe, sclk_o, sclk_oe;
  logic        pol = 1'h0;
  logic        pha = 1'h0;
  logic        slow = 1'h0;
  logic        sel_n = 1'h1;
  logic        txen = 1'h1;
  logic        oe_bad = 1'h0;
  logic        part_somi;
  logic [4:0]  len = 5'h01;
  int          error_cnt, check_count, cyc;
  wire logic   somi_w = somi_oe ? somi_o : part_somi;
  wire logic   simo_w = simo_oe ? simo_o : ~simo_o;
  wire logic   ste_w = ste_oe ? ste_o : sel_n;
  wire logic   sclk_w = sclk_oe ? sclk_o : ~sclk_o;

  serial_port DUT (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .irq_out(irq),
    .slave_out_master_in_pin_in(somi_w), .slave_out_master_in_pin_out(somi_o),
    .slave_out_master_in_pin_oe_out(somi_oe), .slave_in_master_out_pin_in(simo_w),
    .slave_in_master_out_pin_out(simo_o), .slave_in_master_out_pin_oe_out(simo_oe),
    .slave_transmit_enable_pin_in(ste_w), .slave_transmit_enable_pin_out(ste_o),
    .slave_transmit_enable_pin_oe_out(ste_oe), .serial_clock_pin_in(sclk_w),
    .serial_clock_pin_out(sclk_o), .serial_clock_pin_oe_out(sclk_oe));
  link_partner partner (.sclk_in(sclk_w), .sel_n_in(sel_n), .pol_in(pol), .pha_in(pha),
    .slow_in(slow), .len_in(len), .word_in(pw), .simo_in(simo_w), .somi_out(part_somi),
    .rx_out(prx));

  initial begin
    sys_clk_in = 1'h0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    oe_bad <= oe_bad || (!txen && !sel_n && simo_oe);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      close_out;
    end
  end

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One strobe cycle then one idle cycle; read data taken at the second edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    @(posedge sys_clk_in);
    wr_in <= 1'h0;
    rd_in <= 1'h0;
    @(posedge sys_clk_in);
    rd_q = rdata;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    acc(1'h0, a, 16'h0000);
    chk(rd_q, e);
  endtask
  function automatic logic [15:0] msk(input logic [15:0] w, input logic [4:0] l);
    logic [16:0] m;
    m = (17'h00001 << l) - 17'h00001;
    return w & m[15:0];
  endfunction

  task automatic xfer(input logic p, input logic h, input logic [4:0] l,
                      input logic te, input logic ie, input logic ab);
    int          n;
    logic [15:0] hi;
    pol = p;
    pha = h;
    len = l;
    txen = te;
    slow = h;
    tx = 16'($urandom);
    pw = 16'($urandom);
    acc(1'h1, 4'h3, 16'h000b);
    acc(1'h1, 4'h1, {12'h000, h, ie, te, 1'h1});
    acc(1'h1, 4'h0, {8'h00, 1'h1, p, 2'h2, l[3:0] - 4'h1});
    repeat (8) @(posedge sys_clk_in);
    chk({15'h0000, sclk_o}, {15'h0000, p});
    sel_n <= 1'h0;
    @(posedge sys_clk_in);
    acc(1'h1, 4'h6, {8'h00, tx[15:8]});
    acc(1'h1, 4'h7, {8'h00, tx[7:0]});
    if (ab) begin
      repeat (30) @(posedge sys_clk_in);
      acc(1'h1, 4'h0, {8'h00, 1'h0, p, 6'h2f});
      repeat (40) @(posedge sys_clk_in);
      chk({15'h0000, sclk_o}, {15'h0000, p});
      chk({15'h0000, irq}, 16'h0000);
    end else begin
      n = 0;
      do begin
        acc(1'h0, 4'h2, 16'h0000);
        n++;
      end while (rd_q[7] !== 1'h1 && n < 400);
      chk(rd_q & 16'h0080, 16'h0080);
      chk({15'h0000, irq}, {15'h0000, ie});
      if (te) chk(prx, msk(tx, l));
      chk({15'h0000, oe_bad}, 16'h0000);
      acc(1'h0, 4'h4, 16'h0000);
      hi = rd_q;
      acc(1'h0, 4'h5, 16'h0000);
      chk({hi[7:0], rd_q[7:0]}, msk(pw, l));
      @(posedge sys_clk_in);
      chk({15'h0000, irq}, 16'h0000);
      chk({15'h0000, sclk_o}, {15'h0000, p});
    end
    sel_n <= 1'h1;
    @(posedge sys_clk_in);
  endtask

  initial begin
    void'($urandom(5036));
    repeat (16) @(posedge sys_clk_in);
    srst_in <= 1'h0;
    @(posedge sys_clk_in);
    rd_chk(4'h0, 16'h000f);
    rd_chk(4'h1, 16'h0002);
    rd_chk(4'h3, 16'h007f);
    acc(1'h1, 4'h3, 16'hff05);
    rd_chk(4'h3, 16'h0005);
    acc(1'h1, 4'h9, 16'h00ff);
    rd_chk(4'h9, 16'h0000);
    rd_chk(4'hf, 16'h0000);
    acc(1'h1, 4'h8, 16'h0088);
    @(posedge sys_clk_in);
    chk({14'h0000, sclk_oe, sclk_o}, 16'h0003);
    acc(1'h1, 4'h8, 16'h0000);
    for (int m = 0; m < 6; m++) begin
      xfer(m[1], m[0], (m == 0) ? 5'h10 : (m == 3) ? 5'h01 : 5'($urandom_range(1, 16)),
           1'h1, 1'h1, 1'h0);
    end
    xfer(1'h0, 1'h1, 5'h09, 1'h0, 1'h0, 1'h0);
    xfer(1'h1, 1'h0, 5'h10, 1'h1, 1'h1, 1'h1);
    close_out;
  end
endmodule // tb
`default_nettype wire
